// *** rtl/dpsc_ctrl.sv ***
/*
 * Controller that drives one port of a two-port static RAM with
 * semaphores, mailbox flag and busy line. Software reaches it over a
 * classic Wishbone slave. Assumes the RAM pins are synchronous to clk_i.
 */
// Notes on behaviour
// - system wires master busy output to every slave busy input.
// - controller waits for busy to settle before writing a slave.
// - claim by writing zero then reading back; zero means owned.
// - release select or output enable for idle gap before readback.
// - semaphore access only with semaphore select low, chip enable high.
`timescale 1ns/1ps
module dpsc_ctrl #(
	parameter int unsigned ADDR_W = 13,
	parameter int unsigned DATA_W = 16
) (
	// system
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [3:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	// ram port pins
	output logic                   chip_enable_n_o,
	output logic                   read_write_o,
	output logic                   output_enable_n_o,
	output logic                   semaphore_select_n_o,
	output logic                   upper_byte_select_n_o,
	output logic                   lower_byte_select_n_o,
	output logic      [ADDR_W-1:0] addr_o,
	output logic      [DATA_W-1:0] data_o,
	output logic                   data_oe_o,
	input  wire logic [DATA_W-1:0] data_i,
	input  wire logic              busy_n_i,
	input  wire logic              mailbox_flag_n_i
);
	// =====================================================================
	// registers
	logic [5:0]         ctrl_r;
	logic [ADDR_W-1:0]  addr_r;
	logic [DATA_W-1:0]  wdata_r;
	logic [DATA_W-1:0]  rdata_r;
	logic               own_r;
	logic               go_r;
	dpsc_pkg::dpsc_state_t state_r;
	logic [dpsc_pkg::CNT_W-1:0] cnt_r;
	logic               sem_op;

	assign sem_op = ctrl_r[dpsc_pkg::CTRL_SEM];

	// =====================================================================
	// wishbone slave, one wait cycle, ack dropped after one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			ctrl_r   <= 6'h30;
			addr_r   <= '0;
			wdata_r  <= '0;
			go_r     <= 1'b0;
		end else begin
			go_r     <= 1'b0;
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
				wb_dat_o <= 32'h0;
				if (wb_we_i && wb_sel_i[0]) begin
					case (wb_adr_i)
					dpsc_pkg::REG_CTRL: begin
						ctrl_r <= wb_dat_i[5:0];
						go_r   <= wb_dat_i[dpsc_pkg::CTRL_GO]
							&& state_r == dpsc_pkg::ST_IDLE;
					end
					dpsc_pkg::REG_ADDR:  addr_r  <= wb_dat_i[ADDR_W-1:0];
					dpsc_pkg::REG_WDATA: wdata_r <= wb_dat_i[DATA_W-1:0];
					default: ;
					endcase
				end else if (!wb_we_i) begin
					case (wb_adr_i)
					dpsc_pkg::REG_CTRL:
						wb_dat_o <= {26'h0, ctrl_r};
					dpsc_pkg::REG_ADDR:
						wb_dat_o <= {{(32-ADDR_W){1'b0}}, addr_r};
					dpsc_pkg::REG_WDATA:
						wb_dat_o <= {{(32-DATA_W){1'b0}}, wdata_r};
					// busy pin follows the master device
					dpsc_pkg::REG_STATUS:
						wb_dat_o <= {rdata_r[15:0], 12'h0,
							!busy_n_i, !mailbox_flag_n_i, own_r,
							state_r != dpsc_pkg::ST_IDLE};
					default: wb_dat_o <= 32'h0;
					endcase
				end
			end
		end
	end

	// =====================================================================
	// pin sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r               <= dpsc_pkg::ST_IDLE;
			cnt_r                 <= '0;
			chip_enable_n_o       <= 1'b1;
			read_write_o          <= 1'b1;
			output_enable_n_o     <= 1'b1;
			semaphore_select_n_o  <= 1'b1;
			upper_byte_select_n_o <= 1'b1;
			lower_byte_select_n_o <= 1'b1;
			addr_o                <= '0;
			data_o                <= '0;
			data_oe_o             <= 1'b0;
			rdata_r               <= '0;
			own_r                 <= 1'b0;
		end else begin
			case (state_r)
			dpsc_pkg::ST_IDLE: begin
				if (go_r) begin
					addr_o <= addr_r;
					data_o <= sem_op ? {{(DATA_W-1){1'b0}},
						!ctrl_r[dpsc_pkg::CTRL_CLAIM]} : wdata_r;
					upper_byte_select_n_o <= sem_op ||
						!ctrl_r[dpsc_pkg::CTRL_UB];
					lower_byte_select_n_o <= sem_op ||
						!ctrl_r[dpsc_pkg::CTRL_LB];
					cnt_r <= '0;
					state_r <= dpsc_pkg::ST_SETUP;
				end
			end
			dpsc_pkg::ST_SETUP: begin
				// chip enable stays high during semaphore
				chip_enable_n_o      <= sem_op;
				semaphore_select_n_o <= !sem_op;
				cnt_r <= cnt_r + 1'b1;
				// let busy settle before a write strobe
				if (cnt_r >= dpsc_pkg::BUSY_SETTLE_CYC[dpsc_pkg::CNT_W-1:0])
				begin
					cnt_r     <= '0;
					data_oe_o <= ctrl_r[dpsc_pkg::CTRL_WR];
					// write cycle opens only once busy settled
					read_write_o <= !ctrl_r[dpsc_pkg::CTRL_WR];
					output_enable_n_o <= ctrl_r[dpsc_pkg::CTRL_WR];
					state_r   <= dpsc_pkg::ST_STROBE;
				end
			end
			dpsc_pkg::ST_STROBE: begin
				cnt_r <= cnt_r + 1'b1;
				if (cnt_r >= dpsc_pkg::ACCESS_CYC[dpsc_pkg::CNT_W-1:0]) begin
					cnt_r <= '0;
					if (!ctrl_r[dpsc_pkg::CTRL_WR]) begin
						rdata_r <= data_i;
						own_r <= sem_op ? !data_i[0] : own_r;
					end
					chip_enable_n_o      <= 1'b1;
					semaphore_select_n_o <= 1'b1;
					output_enable_n_o    <= 1'b1;
					read_write_o         <= 1'b1;
					data_oe_o            <= 1'b0;
					// semaphore write is followed by readback
					state_r <= (sem_op && ctrl_r[dpsc_pkg::CTRL_WR])
						? dpsc_pkg::ST_GAP : dpsc_pkg::ST_IDLE;
				end
			end
			dpsc_pkg::ST_GAP: begin
				cnt_r <= cnt_r + 1'b1;
				if (cnt_r >= dpsc_pkg::SEM_GAP_CYC[dpsc_pkg::CNT_W-1:0]) begin
					cnt_r <= '0;
					semaphore_select_n_o <= 1'b0;
					output_enable_n_o    <= 1'b0;
					state_r <= dpsc_pkg::ST_VERIFY;
				end
			end
			dpsc_pkg::ST_VERIFY: begin
				cnt_r <= cnt_r + 1'b1;
				if (cnt_r >= dpsc_pkg::ACCESS_CYC[dpsc_pkg::CNT_W-1:0]) begin
					// zero read back means token owned
					rdata_r <= data_i;
					own_r   <= !data_i[0];
					semaphore_select_n_o <= 1'b1;
					output_enable_n_o    <= 1'b1;
					state_r <= dpsc_pkg::ST_IDLE;
				end
			end
			default: state_r <= dpsc_pkg::ST_IDLE;
			endcase
		end
	end

	// =====================================================================
	// checks
	sequence sem_gap_entry_s;
		state_r == dpsc_pkg::ST_STROBE ##1 state_r == dpsc_pkg::ST_GAP;
	endsequence
	sequence sem_readback_s;
		!semaphore_select_n_o && !output_enable_n_o && read_write_o
			&& chip_enable_n_o;
	endsequence
	// no chip enable with semaphore select
	no_ce_sem_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!(!chip_enable_n_o && !semaphore_select_n_o))
		else $error("chip enable and semaphore select both low");
	// byte selects stay high on semaphore
	sem_lanes_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!semaphore_select_n_o
		|-> upper_byte_select_n_o && lower_byte_select_n_o)
		else $error("byte select low during semaphore access");
	sem_gap_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$rose(semaphore_select_n_o) && state_r == dpsc_pkg::ST_GAP
		|-> semaphore_select_n_o [*4])
		else $error("semaphore readback too soon");
	write_settle_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$rose(data_oe_o) |-> $past(state_r) == dpsc_pkg::ST_SETUP)
		else $error("write strobe before busy settle");
	rw_settle_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$fell(read_write_o) |-> $past(state_r) == dpsc_pkg::ST_SETUP)
		else $error("write cycle opened before busy settle");
	// semaphore write ends in gap, then readback
	sem_readback_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		sem_gap_entry_s |-> ##5 sem_readback_s)
		else $error("semaphore readback missing after write");
endmodule : dpsc_ctrl

// *** rtl/dpsc_pkg.sv ***
/*
 * Package for the dual-port RAM port controller: pin timing counts,
 * control and status field layout, register map, sequencer state codes.
 * Assumes a 250 MHz system clock.
 */
package dpsc_pkg;
	localparam int unsigned CLK_PERIOD_PS = 4000;
	// gap after semaphore write before readback, ns
	localparam int unsigned SEM_WRITE_IDLE_GAP_NS = 15;
	localparam int unsigned SEM_GAP_CYC =
		(SEM_WRITE_IDLE_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// busy settle after enable or address match, ns
	localparam int unsigned BUSY_SETTLE_NS = 45;
	localparam int unsigned BUSY_SETTLE_CYC =
		(BUSY_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// access time of a cycle on the pins, ns
	localparam int unsigned ACCESS_NS = 55;
	localparam int unsigned ACCESS_CYC =
		(ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned CNT_W = 8;
	// register offsets
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_ADDR   = 4'h4;
	localparam logic [3:0] REG_WDATA  = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hc;
	// control fields
	localparam int unsigned CTRL_GO   = 0;
	localparam int unsigned CTRL_WR   = 1;
	localparam int unsigned CTRL_SEM  = 2;
	localparam int unsigned CTRL_CLAIM = 3;
	localparam int unsigned CTRL_UB   = 4;
	localparam int unsigned CTRL_LB   = 5;
	// status fields
	localparam int unsigned ST_BUSY  = 0;
	localparam int unsigned ST_OWN   = 1;
	localparam int unsigned ST_MBOX  = 2;
	localparam int unsigned ST_BUSYP = 3;
	localparam int unsigned ST_RDATA = 16;
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_SETUP  = 3'b001,
		ST_STROBE = 3'b011,
		ST_GAP    = 3'b010,
		ST_VERIFY = 3'b110
	} dpsc_state_t;
endpackage : dpsc_pkg

// *** verification/dpsc_ram_model.sv ***
/* far side of one ram port: semaphore latches, memory, mailbox flag.
   assumes the pins are sampled on the controller clock. */
`timescale 1ns/1ps
// ====================
// ram port model
module dpsc_ram_model #(
	parameter int unsigned AW = 13
) (
	// port pins
	input  wire logic          clk_i,
	input  wire logic          ce_n_i,
	input  wire logic          rw_i,
	input  wire logic          oe_n_i,
	input  wire logic          sem_n_i,
	input  wire logic          ub_n_i,
	input  wire logic          lb_n_i,
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [15:0]   dat_i,
	input  wire logic          dat_oe_i,
	output logic      [15:0]   dat_o,
	output logic               busy_n_o,
	output logic               mbox_n_o,
	output logic               far_mbox_n_o,
	// opposite port commands
	input  wire logic          busy_ext_n_i,
	input  wire logic          far_sem_we_i,
	input  wire logic [2:0]    far_sem_idx_i,
	input  wire logic          far_sem_bit_i,
	input  wire logic          far_mbox_we_i
);
	// latches start free, apart from memory
	logic [1:0]  own [8] = '{default: 2'd0};
	logic [7:0]  pend [3] = '{default: 8'h00};
	logic        hold = 1'b1, mb = 1'b1, fmb = 1'b1;
	logic [15:0] last = 16'h0000, drv, val;
	logic [15:0] mem [2**AW];
	logic        rd_mem;
	assign busy_n_o = busy_ext_n_i;
	assign mbox_n_o = mb;
	assign far_mbox_n_o = fmb;
	assign rd_mem = !ce_n_i && rw_i && !oe_n_i && sem_n_i;
	// one owner, a pending claim per side
	task automatic semw(input int s, input logic [2:0] i, input logic b);
		if (!b && own[i] == 2'd0) own[i] = 2'(s);
		else if (!b && own[i] != 2'(s)) pend[s][i] = 1'b1;
		else if (b && own[i] == 2'(s)) begin
			own[i] = pend[3-s][i] ? 2'(3 - s) : 2'd0;
			pend[3-s][i] = 1'b0;
		end else if (b) pend[s][i] = 1'b0;
	endtask : semw
	always @(posedge clk_i) begin
		// latch write, near port first on a tie
		if (!sem_n_i && !rw_i && ce_n_i && dat_oe_i)
			semw(1, addr_i[2:0], dat_i[0]);
		if (far_sem_we_i) semw(2, far_sem_idx_i, far_sem_bit_i);
		if (!ce_n_i && !rw_i && sem_n_i && dat_oe_i) begin
			if (!ub_n_i) mem[addr_i][15:8] = dat_i[15:8];
			if (!lb_n_i) mem[addr_i][7:0] = dat_i[7:0];
		end
		// value frozen while a read runs
		if (oe_n_i || sem_n_i) hold = own[addr_i[2:0]] != 2'd1;
		if (far_mbox_we_i) mb = 1'b0;
		else if (rd_mem && addr_i == {{(AW-1){1'b1}}, 1'b0} && busy_n_o)
			mb = 1'b1;
		// top word write raises the far port's flag
		if (!ce_n_i && !rw_i && sem_n_i && dat_oe_i && busy_n_o
			&& addr_i == {AW{1'b1}})
			fmb = 1'b0;
		last = dat_o;
	end
	always_comb begin
		drv = 16'h0000;
		val = {16{hold}};
		if (!oe_n_i && rw_i && !sem_n_i && (ce_n_i || (ub_n_i && lb_n_i)))
			drv = 16'hffff;
		else if (rd_mem) begin
			drv = {{8{!ub_n_i}}, {8{!lb_n_i}}};
			val = mem[addr_i];
		end
	end
	// released lines show no stale value
	assign dat_o = (drv & val) | (~drv & (dat_oe_i ? dat_i : ~last));
endmodule : dpsc_ram_model

// *** verification/testbench.sv ***
/* bench: wishbone driver, ram port model, queued status checks.
   assumes controller and model share clk_i. */
`timescale 1ns/1ps
// ====================
// testbench top
module testbench;
	logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0, polling = 1'b0, busy_m_n = 1'b1, fs_bit = 1'b0;
	logic fs_we = 1'b0, fm_we = 1'b0;
	logic [2:0]  fs_idx = 3'h0;
	logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hf, sel_v = 4'hf;
	logic        far_mb_n;
	logic [31:0] wb_dat_i = 32'h0, seed = 32'h4f, wb_dat_o, rd, r;
	logic wb_ack_o, ce_n, rw, oe_n, sem_n, ub_n, lb_n, oe, bsy_n, mb_n;
	logic [12:0] adr;
	logic [15:0] dq_o, dq_i, d1;
	logic [63:0] qe [$];
	int          n_fail = 0, check_count = 0;
	dpsc_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .chip_enable_n_o(ce_n), .read_write_o(rw),
		.output_enable_n_o(oe_n), .semaphore_select_n_o(sem_n),
		.upper_byte_select_n_o(ub_n), .lower_byte_select_n_o(lb_n),
		.addr_o(adr), .data_o(dq_o), .data_oe_o(oe), .data_i(dq_i),
		.busy_n_i(bsy_n), .mailbox_flag_n_i(mb_n));
	// master busy wired to this port
	dpsc_ram_model ram_u (.clk_i(clk_i), .ce_n_i(ce_n), .rw_i(rw),
		.oe_n_i(oe_n), .sem_n_i(sem_n), .ub_n_i(ub_n), .lb_n_i(lb_n),
		.addr_i(adr), .dat_i(dq_o), .dat_oe_i(oe), .dat_o(dq_i),
		.busy_n_o(bsy_n), .mbox_n_o(mb_n), .far_mbox_n_o(far_mb_n),
		.busy_ext_n_i(busy_m_n),
		.far_sem_we_i(fs_we), .far_sem_idx_i(fs_idx),
		.far_sem_bit_i(fs_bit), .far_mbox_we_i(fm_we));
	initial forever #2 clk_i = ~clk_i;
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <=
			{2'b11, we, a, d, sel_v};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask : wb
	// pin sequence on go, then status compared under a mask
	task automatic t(input logic [31:0] c, input logic [12:0] a,
		input logic [15:0] d, input logic [31:0] v, input logic [31:0] m);
		wb(1'b1, 4'h4, {19'h0, a});
		wb(1'b1, 4'h8, {16'h0, d});
		wb(1'b1, 4'h0, c);
		polling <= 1'b1;
		do wb(1'b0, 4'hc, 32'h0); while (rd[0] !== 1'b0);
		polling <= 1'b0;
		qe.push_back({v, m});
		wb(1'b0, 4'hc, 32'h0);
	endtask : t
	task automatic far(input logic s, input logic mw, input logic [2:0] i,
		input logic b);
		@(posedge clk_i);
		{fs_we, fm_we, fs_idx, fs_bit} <= {s, mw, i, b};
		@(posedge clk_i);
		{fs_we, fm_we} <= 2'b00;
	endtask : far
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && !wb_we_i && !polling) begin
			check_count++;
			if (qe.size() == 0 || (wb_dat_o & qe[0][31:0]) !== qe[0][63:32]) begin
				n_fail++;
				$display("mismatch t=%0t read %h", $time, wb_dat_o);
			end
			if (qe.size() != 0) void'(qe.pop_front());
		end
	end
	initial begin
		repeat (50000) @(posedge clk_i);
		n_fail++;
		$display("mismatch t=%0t watchdog expired", $time);
		results();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			r = xs();
			t(32'h0f, {r[12:3], 3'(i)}, '0, 32'h2, 32'hffff0002);
			t(32'h07, {r[22:13], 3'(i)}, '0, 32'hffff0000, 32'hffff0002);
		end
		$display("test semaphore claims done");
		far(1'b1, 1'b0, 3'd3, 1'b0);
		t(32'h0f, 13'h3, '0, 32'hffff0000, 32'hffff0002);
		far(1'b1, 1'b0, 3'd3, 1'b1);
		t(32'h05, 13'h3, '0, 32'h2, 32'hffff0002);
		far(1'b1, 1'b0, 3'd3, 1'b0);
		t(32'h07, 13'h3, '0, 32'hffff0000, 32'hffff0002);
		far(1'b1, 1'b0, 3'd3, 1'b1);
		$display("test semaphore hand-over done");
		r = xs();
		d1 = r[15:0];
		t(32'h33, {1'b0, r[27:16]}, d1, 32'h0, 32'hf);
		t(32'h31, {1'b0, r[27:16]}, '0, {d1, 16'h0}, 32'hffff0000);
		t(32'h13, {1'b0, r[27:16]}, ~d1, 32'h0, 32'hf);
		t(32'h31, {1'b0, r[27:16]}, '0, {~d1[15:8], d1[7:0], 16'h0},
			32'hffff0000);
		$display("test byte lanes done");
		far(1'b0, 1'b1, 3'd0, 1'b0);
		t(32'h0, 13'h0, '0, 32'h4, 32'hc);
		busy_m_n <= 1'b0;
		t(32'h31, 13'h1ffe, '0, 32'hc, 32'hc);
		busy_m_n <= 1'b1;
		t(32'h31, 13'h1ffe, '0, 32'h0, 32'hc);
		t(32'h33, 13'h1fff, d1, 32'h0, 32'hf);
		check_count++;
		if (far_mb_n !== 1'b0) begin
			n_fail++;
			$display("mismatch t=%0t far mailbox flag not set", $time);
		end
		// write with sel bit zero must be ignored
		sel_v = 4'he;
		wb(1'b1, 4'h4, 32'h0);
		sel_v = 4'hf;
		qe.push_back({32'h1fff, 32'hffffffff});
		wb(1'b0, 4'h4, 32'h0);
		qe.push_back({32'h0, 32'hffffffff});
		wb(1'b0, 4'h2, 32'h0);
		$display("test mailbox done");
		results();
	end
endmodule : testbench
